// ==== dv/fsac_chk.sv ====
/*
 fsac_chk: port-level timing checks for the flash self-access controller.
 Assumes it is bound onto fsac_ctrl and handed the same WR_CYC.
*/
`timescale 1ns/1ps
module fsac_chk
   import fsac_pkg::*;
#(
   parameter int WR_CYC = 20
) (
   input wire logic                          clk,
   input wire logic                          srst,
   input wire logic [2:0]                    reg_addr,
   input wire logic [7:0]                    reg_wdata,
   input wire logic                          reg_wr,
   input wire logic                          reg_rd,
   input wire logic [7:0]                    reg_rdata,
   input wire logic [1:0]                    self_write_protect_sel,
   input wire logic                          code_protect_n,
   input wire logic                          ext_prog_mode,
   input wire logic                          ext_wr_req,
   input wire logic [fsac_pkg::ADDR_W-1:0]   ext_addr,
   input wire logic [fsac_pkg::DATA_W-1:0]   ext_wdata,
   input wire logic [fsac_pkg::DATA_W-1:0]   fl_rdata,
   input wire logic [fsac_pkg::ADDR_W-1:0]   fl_addr,
   input wire logic [fsac_pkg::DATA_W-1:0]   fl_wdata,
   input wire logic                          fl_calib,
   input wire logic                          fl_rd_req,
   input wire logic                          fl_erase,
   input wire logic                          fl_prog,
   input wire logic                          cpu_discard,
   input wire logic                          cpu_stall,
   input wire logic                          test_access_en
);
   int stall_cnt;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // length of the current stall, so its bound can be checked
   always_ff @(posedge clk) begin
      if (srst || !cpu_stall) begin
         stall_cnt <= 0;
      end else begin
         stall_cnt <= stall_cnt + 1;
      end
   end

   rd_discard_a: assert property (fl_rd_req |-> cpu_discard)
      else $error("flash fetch without dropped instruction");
   unlock_zero_a: assert property (
      reg_rd && reg_addr == REG_UNLOCK |=> reg_rdata == 8'h00)
      else $error("unlock register read not zero");
   stall_erase_a: assert property ($rose(cpu_stall) |-> fl_erase)
      else $error("stall began without erase");
   erase_row_a: assert property (
      fl_erase |-> fl_addr[3:0] == 4'h0 && cpu_stall)
      else $error("erase not row aligned or not stalled");
   prog_after_erase_a: assert property (fl_erase |-> ##[1:4] fl_prog)
      else $error("no programming after erase");
   prog_stall_a: assert property (
      fl_prog && !ext_prog_mode |-> cpu_stall)
      else $error("self programming outside commit");
   stall_min_a: assert property (
      $fell(cpu_stall) |-> $past(stall_cnt) >= WR_CYC)
      else $error("stall shorter than write time");
   stall_max_a: assert property (stall_cnt < WR_CYC + 64)
      else $error("stall did not end");
   test_mirror_a: assert property (
      !$past(srst) |-> test_access_en == $past(code_protect_n))
      else $error("test access does not follow code protect");

   cover property ($rose(cpu_stall));
   cover property (fl_rd_req);
   cover property (ext_prog_mode && fl_prog);
endmodule // fsac_chk

// ==== dv/fsac_flash_mdl.sv ====
/*
 fsac_flash_mdl: behavioural flash array behind the controller.
 Assumes registered strobes; read data stands only the cycle after a read.
*/
`timescale 1ns/1ps
module fsac_flash_mdl
   import fsac_pkg::*;
#(
   parameter logic [13:0] CAL_WORD = 14'h1234
) (
   input wire logic                        clk,
   input wire logic [fsac_pkg::ADDR_W-1:0] fl_addr,
   input wire logic [fsac_pkg::DATA_W-1:0] fl_wdata,
   input wire logic                        fl_calib,
   input wire logic                        fl_rd_req,
   input wire logic                        fl_erase,
   input wire logic                        fl_prog,
   output logic     [fsac_pkg::DATA_W-1:0] fl_rdata
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   initial fl_rdata = '0;

   always @(posedge clk) begin
      if (fl_erase) begin
         for (int i = 0; i < 16; i++) begin
            mem[{fl_addr[ADDR_W-1:4], i[3:0]}] = '1;
         end
      end
      if (fl_prog) begin
         mem[fl_addr] = fl_wdata;
      end
      // stale data is inverted so a late capture cannot pass by luck
      if (fl_rd_req) begin
         fl_rdata <= fl_calib ? CAL_WORD : mem[fl_addr];
      end else begin
         fl_rdata <= ~fl_rdata;
      end
   end
endmodule // fsac_flash_mdl

// ==== dv/test_program_flash_self_access_control.sv ====
/*
 test_program_flash_self_access_control: directed bench for fsac_ctrl.
 Assumes the flash model answers reads one cycle after the request.
*/
`timescale 1ns/1ps
module test_program_flash_self_access_control;
   import fsac_pkg::*;
   logic                clk, srst, reg_wr, reg_rd, code_protect_n;
   logic                ext_prog_mode, ext_wr_req, fl_calib, fl_rd_req;
   logic                fl_erase, fl_prog, cpu_discard, cpu_stall;
   logic                test_access_en;
   logic [2:0]          reg_addr;
   logic [7:0]          reg_wdata, reg_rdata;
   logic [1:0]          self_write_protect_sel;
   logic [ADDR_W-1:0]   ext_addr, fl_addr;
   logic [DATA_W-1:0]   ext_wdata, fl_rdata, fl_wdata;
   int                  failures, num_checks;

   fsac_ctrl #(.WR_CYC(20), .PWRT_CYC(30)) DUT (.clk(clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .self_write_protect_sel(self_write_protect_sel),
      .code_protect_n(code_protect_n), .ext_prog_mode(ext_prog_mode),
      .ext_wr_req(ext_wr_req), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
      .fl_rdata(fl_rdata), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
      .fl_calib(fl_calib), .fl_rd_req(fl_rd_req), .fl_erase(fl_erase),
      .fl_prog(fl_prog), .cpu_discard(cpu_discard), .cpu_stall(cpu_stall),
      .test_access_en(test_access_en));
   fsac_flash_mdl u_flash (.clk(clk), .fl_addr(fl_addr),
      .fl_wdata(fl_wdata), .fl_calib(fl_calib), .fl_rd_req(fl_rd_req),
      .fl_erase(fl_erase), .fl_prog(fl_prog), .fl_rdata(fl_rdata));

   initial clk = 1'b0;
   always #25 clk = ~clk;

   task wrap_up;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input logic [13:0] got, input logic [13:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task reg_write(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk) begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
      end
      @(posedge clk) reg_wr <= 1'b0;
   endtask

   task reg_read(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk) begin
         reg_addr <= a;
         reg_rd <= 1'b1;
      end
      @(posedge clk) reg_rd <= 1'b0;
      @(negedge clk) d = reg_rdata;
   endtask

   task unlock(input logic brk);
      logic [7:0] d;
      reg_write(REG_UNLOCK, UNLOCK_KEY1);
      if (brk) reg_read(REG_ADDR_LOW, d);
      reg_write(REG_UNLOCK, UNLOCK_KEY2);
   endtask

   task wait_idle;
      logic [7:0] d;
      d = 8'hff;
      for (int n = 0; n < 200 && d[1] !== 1'b0; n++) reg_read(REG_CTRL, d);
      chk({13'h0, d[1]}, 14'h0);
   endtask

   // word write at 00Fh that must be refused; flash and write bit unchanged
   task t_refuse(input logic [1:0] sel, input logic [7:0] pre, val,
                 input logic brk);
      logic [7:0] d;
      @(posedge clk) self_write_protect_sel <= sel;
      reg_write(REG_CTRL, pre);
      reg_write(REG_ADDR_LOW, 8'h0f);
      reg_write(REG_ADDR_HIGH, 8'h00);
      unlock(brk);
      reg_write(REG_CTRL, val);
      repeat (4) @(posedge clk);
      reg_read(REG_CTRL, d);
      chk({6'h0, d}, {6'h0, 8'h80 | (val & 8'h44)});
      chk(u_flash.mem[15], 14'h0abc);
      $display("refusal case %h done", val);
   endtask

   task t_regs;
      logic [7:0] d;
      reg_read(REG_UNLOCK, d);
      chk({6'h0, d}, 14'h0);
      reg_read(3'h6, d);
      chk({6'h0, d}, 14'h0);
      chk({13'h0, test_access_en}, 14'h1);
      $display("register map test done");
   endtask

   task t_read;
      logic [7:0] lo, hi;
      reg_write(REG_ADDR_LOW, 8'h5c);
      reg_write(REG_ADDR_HIGH, 8'h1a);
      reg_write(REG_CTRL, 8'h01);
      repeat (4) @(posedge clk);
      reg_read(REG_DATA_LOW, lo);
      reg_read(REG_DATA_HIGH, hi);
      chk({hi[5:0], lo}, 14'h2bcd);
      chk({6'h0, hi[7:6], 6'h0}, 14'h0);
      reg_read(REG_CTRL, lo);
      chk({6'h0, lo}, 14'h0080);
      reg_read(REG_DATA_LOW, lo);
      chk({6'h0, lo}, 14'h00cd);
      reg_write(REG_CTRL, 8'h41);
      repeat (4) @(posedge clk);
      reg_read(REG_DATA_LOW, lo);
      reg_read(REG_DATA_HIGH, hi);
      chk({hi[5:0], lo}, 14'h1234);
      $display("read test done");
   endtask

   task t_block;
      reg_write(REG_CTRL, 8'h04);
      for (logic [7:0] i = 0; i < 8; i++) begin
         reg_write(REG_ADDR_LOW, 8'h08 + i);
         reg_write(REG_ADDR_HIGH, 8'h04);
         reg_write(REG_DATA_LOW, i);
         reg_write(REG_DATA_HIGH, 8'h3a);
         unlock(1'b0);
         reg_write(REG_CTRL, 8'h06);
         repeat (2) @(posedge clk);
         wait_idle;
      end
      for (int i = 0; i < 8; i++) begin
         chk(u_flash.mem[13'h408 + i], 14'h3a00 | 14'(i));
      end
      chk(u_flash.mem[13'h400], 14'h3fff);
      $display("block write test done");
   endtask

   task t_ext;
      @(posedge clk) begin
         ext_prog_mode <= 1'b1;
         self_write_protect_sel <= 2'h0;
         ext_addr <= 13'h0020;
         ext_wdata <= 14'h1555;
         ext_wr_req <= 1'b1;
      end
      @(posedge clk) ext_wr_req <= 1'b0;
      repeat (3) @(posedge clk);
      chk(u_flash.mem[32], 14'h1555);
      code_protect_n <= 1'b0;
      ext_addr <= 13'h0021;
      ext_wr_req <= 1'b1;
      @(posedge clk) ext_wr_req <= 1'b0;
      repeat (3) @(posedge clk);
      chk(u_flash.mem[33], 14'h0777);
      chk({13'h0, test_access_en}, 14'h0);
      ext_prog_mode <= 1'b0;
      code_protect_n <= 1'b1;
      $display("external programming test done");
   endtask

   initial begin
      #(50 * 20000);
      failures++;
      wrap_up;
   end

   initial begin
      failures = 0;
      num_checks = 0;
      srst = 1'b1;
      {reg_addr, reg_wdata, reg_wr, reg_rd, ext_wr_req} = '0;
      {ext_addr, ext_wdata, ext_prog_mode} = '0;
      self_write_protect_sel = WP_NONE;
      code_protect_n = 1'b1;
      u_flash.mem[15] = 14'h0abc;
      u_flash.mem[13'h1a5c] = 14'h2bcd;
      u_flash.mem[13'h400] = 14'h1111;
      u_flash.mem[33] = 14'h0777;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      t_refuse(WP_NONE, 8'h04, 8'h06, 1'b0);
      repeat (40) @(posedge clk);
      t_refuse(WP_NONE, 8'h04, 8'h06, 1'b1);
      t_refuse(WP_LOW, 8'h04, 8'h06, 1'b0);
      t_refuse(WP_NONE, 8'h04, 8'h46, 1'b0);
      t_refuse(WP_NONE, 8'h00, 8'h06, 1'b0);
      t_regs;
      t_read;
      t_block;
      t_ext;
      wrap_up;
   end
endmodule // test_program_flash_self_access_control

bind fsac_ctrl fsac_chk #(.WR_CYC(WR_CYC)) u_chk (.clk(clk), .srst(srst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .self_write_protect_sel(self_write_protect_sel),
   .code_protect_n(code_protect_n), .ext_prog_mode(ext_prog_mode),
   .ext_wr_req(ext_wr_req), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
   .fl_rdata(fl_rdata), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
   .fl_calib(fl_calib), .fl_rd_req(fl_rd_req), .fl_erase(fl_erase),
   .fl_prog(fl_prog), .cpu_discard(cpu_discard), .cpu_stall(cpu_stall),
   .test_access_en(test_access_en));

// ==== pkg/fsac_pkg.sv ====
/*
 fsac_pkg: constants and types shared by the program flash self-access
 controller, its write buffer and its delay timer.
 Assumes a 20 MHz instruction clock and an 8-bit register port.
*/
package fsac_pkg;
   localparam int ADDR_W    = 13;
   localparam int DATA_W    = 14;
   localparam int BUF_DEPTH = 8;
   localparam int BUF_IDX_W = 3;
   localparam int TMR_W     = 21;

   // register indices on the register port
   localparam logic [2:0] REG_ADDR_LOW  = 3'h0;
   localparam logic [2:0] REG_ADDR_HIGH = 3'h1;
   localparam logic [2:0] REG_DATA_LOW  = 3'h2;
   localparam logic [2:0] REG_DATA_HIGH = 3'h3;
   localparam logic [2:0] REG_CTRL      = 3'h4;
   localparam logic [2:0] REG_UNLOCK    = 3'h5;

   // flash_ctrl bit positions
   localparam int CTRL_RD    = 0;
   localparam int CTRL_WR    = 1;
   localparam int CTRL_WEN   = 2;
   localparam int CTRL_CAL   = 6;
   localparam int CTRL_FIXED = 7;

   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'haa;

   localparam logic [2:0] BLOCK_LAST = 3'h7;
   localparam logic [3:0] ERASE_MASK = 4'h3;
   localparam logic [3:0] ERASE_PAT  = 4'h3;
   localparam int         ROW_W      = 4;

   // self-write protect selector codes and protected upper bounds
   localparam logic [1:0]        WP_NONE     = 2'h3;
   localparam logic [1:0]        WP_LOW      = 2'h2;
   localparam logic [1:0]        WP_HALF     = 2'h1;
   localparam logic [ADDR_W-1:0] WP_LOW_TOP  = 13'h03ff;
   localparam logic [ADDR_W-1:0] WP_HALF_TOP = 13'h0fff;

   localparam int CLK_MHZ      = 20;
   localparam int WR_TIME_US   = 4000;
   localparam int WR_CYCLES    = WR_TIME_US * CLK_MHZ;
   localparam int PWRT_TIME_MS = 72;
   localparam int PWRT_CYCLES  = PWRT_TIME_MS * 1000 * CLK_MHZ;

   typedef enum logic [3:0] {
      S_IDLE, S_RD_WAIT, S_RD_FETCH, S_RD_CAPT, S_SETUP, S_STORE,
      S_ERASE, S_PROG_RD, S_PROG_WR, S_WAIT, S_DONE
   } fsac_state_t;
endpackage

// ==== src/fsac_buf.sv ====
/*
 fsac_buf: the eight-word write buffer in front of the flash array.
 Assumes one writer and one reader on the same clock; read data is
 registered and appears one cycle after the read address.
*/
`timescale 1ns/1ps
module fsac_buf #(
   parameter int W  = 14,
   parameter int D  = 8,
   parameter int AW = 3
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [W-1:0]  rdata
);
   logic [W-1:0] mem [D];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      rdata <= mem[raddr];
   end
endmodule // fsac_buf

// ==== src/fsac_ctrl.sv ====
/*
 fsac_ctrl: program flash self-access controller. Software reads and
 writes single flash words through address, data, control and unlock
 registers; writes gather in an eight-word buffer and commit with an
 erase followed by programming while the core is stalled.
 Assumes the register port master of the core, a flash array that
 returns read data the cycle after fl_rd_req, and a core that squashes
 an instruction on cpu_discard and holds while cpu_stall is high.
*/
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - the second cycle after the read bit fetches; that instruction is dropped.
// - the fetched word lands in both data registers the next cycle.
// - data registers keep the word until another read or software write.
// - self-writes happen only outside segments chosen by write protect.
// - protect bits ignored in external programming; code protect blocks it.
// - writes gather in aligned eight-word blocks, never across a boundary.
// - each commit erases a sixteen-word row, then programs eight words.
// - a write at low address bits 111 erases and programs the block.
// - two setup cycles follow the write bit; software places two nops.
// - buffer writes end at once; commit stalls the core about 4 ms.
// - after the commit the core resumes at the third instruction.
// - erase happens only when low address bits match the erase pattern.
// - write allow clears at power-up; writes blocked during power-up timer.
// - writes need write allow and a correct unlock sequence.
// - code protection keeps core access but disables test memory access.
// - write protection still allows reads of all program memory.
// - read and write bits are set-only; hardware clears them when done.
// - calibration select steers reads to test space and blocks writes.
// - data registers form a 14-bit word, address registers 13 bits.
// - the unlock register stores nothing and reads as zero.
module fsac_ctrl
   import fsac_pkg::*;
#(
   parameter int WR_CYC   = fsac_pkg::WR_CYCLES,
   parameter int PWRT_CYC = fsac_pkg::PWRT_CYCLES
) (
   input  wire logic                  clk,
   input  wire logic                  srst,
   input  wire logic [2:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [7:0]            reg_rdata,
   input  wire logic [1:0]            self_write_protect_sel,
   input  wire logic                  code_protect_n,
   input  wire logic                  ext_prog_mode,
   input  wire logic                  ext_wr_req,
   input  wire logic [fsac_pkg::ADDR_W-1:0] ext_addr,
   input  wire logic [fsac_pkg::DATA_W-1:0] ext_wdata,
   input  wire logic [fsac_pkg::DATA_W-1:0] fl_rdata,
   output logic      [fsac_pkg::ADDR_W-1:0] fl_addr,
   output logic      [fsac_pkg::DATA_W-1:0] fl_wdata,
   output logic                       fl_calib,
   output logic                       fl_rd_req,
   output logic                       fl_erase,
   output logic                       fl_prog,
   output logic                       cpu_discard,
   output logic                       cpu_stall,
   output logic                       test_access_en
);
   import fsac_pkg::*;

   fsac_state_t           state;
   logic [7:0]            flash_addr_low;
   // five high bits so the word address spans all 13 bits
   logic [4:0]            flash_addr_high;
   logic [7:0]            flash_data_low;
   logic [5:0]            flash_data_high;
   logic                  rd_bit;
   logic                  wr_bit;
   logic                  write_allow;
   logic                  calib_space_sel;
   logic [1:0]            unlock_step;
   logic [BUF_IDX_W-1:0]  prog_idx;
   logic                  pwrt_kick;
   logic                  pwrt_done;
   logic                  wr_tmr_start;
   logic                  wr_tmr_done;
   logic [DATA_W-1:0]     buf_rdata;
   logic                  buf_we;
   logic [ADDR_W-1:0]     cur_addr;
   logic                  seg_protected;
   logic                  wr_ok;
   logic                  ctrl_wr;
   logic                  commit;

   assign cur_addr = {flash_addr_high, flash_addr_low};
   assign ctrl_wr  = reg_wr && reg_addr == REG_CTRL;
   assign commit   = flash_addr_low[2:0] == BLOCK_LAST;
   assign buf_we   = state == S_STORE;

   always_comb begin
      case (self_write_protect_sel)
         WP_NONE: seg_protected = 1'b0;
         WP_LOW:  seg_protected = cur_addr <= WP_LOW_TOP;
         WP_HALF: seg_protected = cur_addr <= WP_HALF_TOP;
         default: seg_protected = 1'b1;
      endcase
   end

   // every guard must hold for the write bit to be taken at all
   assign wr_ok = reg_wdata[CTRL_WR] && unlock_step == 2'd2
      && write_allow
      && pwrt_done
      && !reg_wdata[CTRL_CAL] && !calib_space_sel
      && !seg_protected
      && !ext_prog_mode && state == S_IDLE;

   // unlock recognition: any access other than the next expected one
   // restarts it, so a stray access between keys voids the sequence
   always_ff @(posedge clk) begin
      if (srst) begin
         unlock_step <= 2'd0;
      end else if (reg_wr || reg_rd) begin
         if (reg_wr && reg_addr == REG_UNLOCK
             && reg_wdata == UNLOCK_KEY1) begin
            unlock_step <= 2'd1;
         end else if (reg_wr && reg_addr == REG_UNLOCK
                      && reg_wdata == UNLOCK_KEY2
                      && unlock_step == 2'd1) begin
            unlock_step <= 2'd2;
         end else begin
            unlock_step <= 2'd0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         flash_addr_low  <= '0;
         flash_addr_high <= '0;
      end else if (reg_wr && reg_addr == REG_ADDR_LOW) begin
         flash_addr_low <= reg_wdata;
      end else if (reg_wr && reg_addr == REG_ADDR_HIGH) begin
         flash_addr_high <= reg_wdata[4:0];
      end
   end

   // a capture wins over software writes when they share a cycle,
   // which the read timing makes impossible for a well-behaved core
   always_ff @(posedge clk) begin
      if (srst) begin
         flash_data_low  <= '0;
         flash_data_high <= '0;
      end else if (state == S_RD_CAPT) begin
         flash_data_low  <= fl_rdata[7:0];
         flash_data_high <= fl_rdata[DATA_W-1:8];
      end else if (reg_wr && reg_addr == REG_DATA_LOW) begin
         flash_data_low <= reg_wdata;
      end else if (reg_wr && reg_addr == REG_DATA_HIGH) begin
         flash_data_high <= reg_wdata[5:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         write_allow     <= 1'b0;
         calib_space_sel <= 1'b0;
      end else if (ctrl_wr) begin
         write_allow     <= reg_wdata[CTRL_WEN];
         calib_space_sel <= reg_wdata[CTRL_CAL];
      end
   end

   // software can only set these bits; only the sequencer clears them
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_bit <= 1'b0;
      end else if (state == S_RD_CAPT) begin
         rd_bit <= 1'b0;
      end else if (ctrl_wr && reg_wdata[CTRL_RD] && state == S_IDLE
                   && !wr_bit) begin
         rd_bit <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_bit <= 1'b0;
      end else if (state == S_DONE) begin
         wr_bit <= 1'b0;
      end else if (ctrl_wr && wr_ok && !rd_bit) begin
         wr_bit <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state    <= S_IDLE;
         prog_idx <= '0;
      end else begin
         case (state)
            S_IDLE: begin
               if (rd_bit) begin
                  state <= S_RD_WAIT;
               end else if (wr_bit) begin
                  state <= S_SETUP;
               end
            end
            S_RD_WAIT: begin
               state <= S_RD_FETCH;
            end
            S_RD_FETCH: begin
               state <= S_RD_CAPT;
            end
            S_RD_CAPT: begin
               state <= S_IDLE;
            end
            S_SETUP: begin
               state <= S_STORE;
            end
            S_STORE: begin
               prog_idx <= '0;
               if (commit) begin
                  state <= S_ERASE;
               end else begin
                  state <= S_DONE;
               end
            end
            S_ERASE: begin
               state <= S_PROG_RD;
            end
            S_PROG_RD: begin
               state <= S_PROG_WR;
            end
            S_PROG_WR: begin
               prog_idx <= prog_idx + BUF_IDX_W'(1);
               if (prog_idx == BLOCK_LAST) begin
                  state <= S_WAIT;
               end else begin
                  state <= S_PROG_RD;
               end
            end
            S_WAIT: begin
               if (wr_tmr_done) begin
                  state <= S_DONE;
               end
            end
            S_DONE: begin
               state <= S_IDLE;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // flash-facing strobes; every output comes from a flop
   always_ff @(posedge clk) begin
      if (srst) begin
         fl_addr   <= '0;
         fl_wdata  <= '0;
         fl_calib  <= 1'b0;
         fl_rd_req <= 1'b0;
         fl_erase  <= 1'b0;
         fl_prog   <= 1'b0;
      end else begin
         fl_rd_req <= 1'b0;
         fl_erase  <= 1'b0;
         fl_prog   <= 1'b0;
         if (state == S_RD_WAIT) begin
            fl_addr   <= cur_addr;
            fl_calib  <= calib_space_sel;
            fl_rd_req <= 1'b1;
         end else if (state == S_STORE && commit) begin
            fl_calib <= 1'b0;
            fl_addr  <= {cur_addr[ADDR_W-1:ROW_W], ROW_W'(0)};
            // row erase only on the pattern; any commit matches it
            fl_erase <= (cur_addr[3:0] & ERASE_MASK) == ERASE_PAT;
         end else if (state == S_PROG_WR) begin
            fl_addr  <= {cur_addr[ADDR_W-1:BUF_IDX_W], prog_idx};
            fl_wdata <= buf_rdata;
            fl_prog  <= 1'b1;
         end else if (state == S_IDLE && ext_prog_mode && ext_wr_req
                      && code_protect_n) begin
            // external programming skips write protect entirely
            fl_calib <= 1'b0;
            fl_addr  <= ext_addr;
            fl_wdata <= ext_wdata;
            fl_prog  <= 1'b1;
         end
      end
   end

   // core-facing controls
   always_ff @(posedge clk) begin
      if (srst) begin
         cpu_discard <= 1'b0;
         cpu_stall   <= 1'b0;
      end else begin
         cpu_discard <= state == S_RD_WAIT;
         if (state == S_STORE && commit) begin
            cpu_stall <= 1'b1;
         end else if (state == S_WAIT && wr_tmr_done) begin
            cpu_stall <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         test_access_en <= 1'b0;
      end else begin
         test_access_en <= code_protect_n;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_ADDR_LOW:  reg_rdata <= flash_addr_low;
            REG_ADDR_HIGH: reg_rdata <= {3'h0, flash_addr_high};
            REG_DATA_LOW:  reg_rdata <= flash_data_low;
            REG_DATA_HIGH: reg_rdata <= {2'h0, flash_data_high};
            REG_CTRL: begin
               reg_rdata             <= '0;
               reg_rdata[CTRL_FIXED] <= 1'b1;
               reg_rdata[CTRL_CAL]   <= calib_space_sel;
               reg_rdata[CTRL_WEN]   <= write_allow;
               reg_rdata[CTRL_WR]    <= wr_bit;
               reg_rdata[CTRL_RD]    <= rd_bit;
            end
            default: reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // power-up hold-off starts on the first cycle after reset release
   always_ff @(posedge clk) begin
      if (srst) begin
         pwrt_kick <= 1'b0;
      end else begin
         pwrt_kick <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_tmr_start <= 1'b0;
      end else begin
         wr_tmr_start <= state == S_ERASE;
      end
   end

   fsac_delay #(.W(TMR_W)) u_pwrt (
      .clk   (clk),
      .srst  (srst),
      .start (!pwrt_kick),
      .load  (TMR_W'(PWRT_CYC)),
      .done  (pwrt_done)
   );

   fsac_delay #(.W(TMR_W)) u_wr_tmr (
      .clk   (clk),
      .srst  (srst),
      .start (wr_tmr_start),
      .load  (TMR_W'(WR_CYC)),
      .done  (wr_tmr_done)
   );

   fsac_buf #(
      .W  (DATA_W),
      .D  (BUF_DEPTH),
      .AW (BUF_IDX_W)
   ) u_buf (
      .clk   (clk),
      .we    (buf_we),
      .waddr (flash_addr_low[BUF_IDX_W-1:0]),
      .wdata ({flash_data_high, flash_data_low}),
      .raddr (prog_idx),
      .rdata (buf_rdata)
   );
endmodule // fsac_ctrl

// ==== src/fsac_delay.sv ====
/*
 fsac_delay: one-shot down counter used for the power-up hold-off and
 for the long erase/program time.
 Assumes start is a one-cycle pulse; done rises when the count expires.
*/
`timescale 1ns/1ps
module fsac_delay #(
   parameter int W = 21
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         start,
   input  wire logic [W-1:0] load,
   output logic              done
);
   logic [W-1:0] count;
   logic         run;

   always_ff @(posedge clk) begin
      if (srst) begin
         count <= '0;
         run   <= 1'b0;
         done  <= 1'b0;
      end else if (start) begin
         count <= load;
         run   <= 1'b1;
         done  <= 1'b0;
      end else if (run) begin
         if (count <= W'(1)) begin
            run  <= 1'b0;
            done <= 1'b1;
         end
         count <= count - W'(1);
      end
   end
endmodule // fsac_delay
